// *** rtl/sio_gpio_dev.sv ***
// GPIO logical device behind a locked index/data configuration port
`timescale 1ns/1ps
`default_nettype none
`include "sio_consts.svh"

// Behaviour
// (RULE1) Two successive unlock writes open configuration
// (RULE2) Lock write closes configuration access
// (RULE3) Index selects register; data port transfers; bank 7
// (RULE4) Bank 9 register 30h bit 7 enables GPIO
// (RULE5) Direction bit one input, zero output
// (RULE6) Input bits of data register ignore writes
// (RULE7) Inversion bit flips pin/data value both ways
// (RULE8) Input pins pass two-stage synchroniser
module sio_gpio_dev (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Configuration port
  sio_port_if.dev            port,
  // Board pins
  input  wire sio_pkg::sio_byte_t gpio_in,
  output var  sio_pkg::sio_byte_t gpio_out,
  output var  sio_pkg::sio_byte_t gpio_oe,
  // Status
  output logic               cfg_open
);
  import sio_pkg::*;

  sio_lock_t lock;
  sio_lock_t next_lock;
  sio_byte_t index;
  sio_byte_t next_index;
  sio_byte_t ldn;
  sio_byte_t next_ldn;
  sio_byte_t gen;
  sio_byte_t next_gen;
  sio_byte_t dir;
  sio_byte_t next_dir;
  sio_byte_t val;
  sio_byte_t next_val;
  sio_byte_t inv;
  sio_byte_t next_inv;
  logic      ack;
  logic      next_ack;
  sio_byte_t rdata;
  sio_byte_t next_rdata;
  sio_byte_t next_out;
  sio_byte_t next_oe;
  sio_byte_t pin_meta;
  sio_byte_t pin_sync;
  sio_reg_t  sel;
  logic      is_idx;
  logic      is_dat;

  // Register addressed by index within the selected bank
  function automatic sio_reg_t reg_decode(input sio_byte_t idx,
                                          input sio_byte_t bank);
    reg_decode = SIO_REG_NONE;
    if (idx == `SIO_LDN_REG) begin
      reg_decode = SIO_REG_LDN;
    end else if (bank == `SIO_BANK_GEN) begin
      if (idx == `SIO_GEN_REG) begin // RULE4
        reg_decode = SIO_REG_GEN;
      end
    end else if (bank == `SIO_BANK_GPIO) begin // RULE3
      case (idx)
        `SIO_DIR_REG: reg_decode = SIO_REG_DIR;
        `SIO_VAL_REG: reg_decode = SIO_REG_VAL;
        `SIO_INV_REG: reg_decode = SIO_REG_INV;
        default:      reg_decode = SIO_REG_NONE;
      endcase
    end
  endfunction

  // Value seen through the data register
  function automatic sio_byte_t data_view(input sio_byte_t d,
                                          input sio_byte_t mask_in,
                                          input sio_byte_t pins,
                                          input sio_byte_t flip);
    data_view = (d & ~mask_in) | ((pins ^ flip) & mask_in); // RULE6 RULE7
  endfunction

  // Pin synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= gpio_in; // RULE8
      pin_sync <= pin_meta; // RULE8
    end
  end

  always_comb begin
    next_lock  = lock;
    next_index = index;
    next_ldn   = ldn;
    next_gen   = gen;
    next_dir   = dir;
    next_val   = val;
    next_inv   = inv;
    next_ack   = 1'b0;
    next_rdata = rdata;
    sel        = reg_decode(index, ldn);
    is_idx     = (port.io_addr == `SIO_INDEX_PORT);
    is_dat     = (port.io_addr == `SIO_DATA_PORT);
    if (port.io_req) begin
      next_ack   = 1'b1;
      next_rdata = `SIO_FILL_BYTE;
      case (lock)
        SIO_LOCKED: begin
          // Any access other than the key is ignored while locked
          if (is_idx && port.io_we &&
              port.io_wdata == `SIO_UNLOCK_KEY) begin
            next_lock = SIO_HALF; // RULE1
          end
        end
        SIO_HALF: begin
          // The second key must be the very next access
          if (is_idx && port.io_we &&
              port.io_wdata == `SIO_UNLOCK_KEY) begin
            next_lock = SIO_OPEN; // RULE1
          end else begin
            next_lock = SIO_LOCKED; // RULE1
          end
        end
        SIO_OPEN: begin
          if (is_idx) begin
            if (port.io_we) begin
              if (port.io_wdata == `SIO_LOCK_KEY) begin
                next_lock = SIO_LOCKED; // RULE2
              end else begin
                next_index = port.io_wdata; // RULE3
              end
            end else begin
              next_rdata = index;
            end
          end else if (is_dat) begin
            if (port.io_we) begin
              case (sel)
                SIO_REG_LDN: next_ldn = port.io_wdata; // RULE3
                SIO_REG_GEN: next_gen = port.io_wdata; // RULE4
                SIO_REG_DIR: next_dir = port.io_wdata; // RULE5
                SIO_REG_VAL: begin
                  next_val = (port.io_wdata & ~dir) | (val & dir); // RULE6
                end
                SIO_REG_INV: next_inv = port.io_wdata; // RULE7
                default:     next_val = val;
              endcase
            end else begin
              case (sel)
                SIO_REG_LDN: next_rdata = ldn;
                SIO_REG_GEN: next_rdata = gen; // RULE4
                SIO_REG_DIR: next_rdata = dir;
                SIO_REG_VAL: begin
                  next_rdata = data_view(val, dir, pin_sync, inv); // RULE6
                end
                SIO_REG_INV: next_rdata = inv;
                default:     next_rdata = `SIO_FILL_BYTE;
              endcase
            end
          end
        end
        default: next_lock = SIO_LOCKED;
      endcase
    end
    // Pins driven only for output bits while GPIO is enabled
    next_out = next_val ^ next_inv; // RULE7
    if (next_gen[`SIO_GEN_BIT]) begin // RULE4
      next_oe = ~next_dir; // RULE5
    end else begin
      next_oe = 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock     <= SIO_LOCKED;
      index    <= `SIO_IDX_RST;
      ldn      <= `SIO_LDN_RST;
      gen      <= `SIO_GEN_RST;
      dir      <= `SIO_DIR_RST;
      val      <= `SIO_VAL_RST;
      inv      <= `SIO_INV_RST;
      ack      <= 1'b0;
      rdata    <= 8'h00;
      gpio_out <= 8'h00;
      gpio_oe  <= 8'h00;
    end else begin
      lock     <= next_lock;
      index    <= next_index;
      ldn      <= next_ldn;
      gen      <= next_gen;
      dir      <= next_dir;
      val      <= next_val;
      inv      <= next_inv;
      ack      <= next_ack;
      rdata    <= next_rdata;
      gpio_out <= next_out;
      gpio_oe  <= next_oe;
    end
  end

  assign port.io_ack   = ack;
  assign port.io_rdata = rdata;
  assign cfg_open      = (lock == SIO_OPEN);

endmodule // sio_gpio_dev

`default_nettype wire

// *** rtl/sio_consts.svh ***
// Constants for the super I/O GPIO configuration port and its controller
`ifndef SIO_CONSTS_SVH
`define SIO_CONSTS_SVH

// Configuration port addresses
`define SIO_INDEX_PORT   8'h2E
`define SIO_DATA_PORT    8'h2F

// Mode keys written to the index port
`define SIO_UNLOCK_KEY   8'h87
`define SIO_LOCK_KEY     8'hAA

// Register numbers
`define SIO_LDN_REG      8'h07
`define SIO_GEN_REG      8'h30
`define SIO_DIR_REG      8'hE0
`define SIO_VAL_REG      8'hE1
`define SIO_INV_REG      8'hE2

// Logical devices (banks)
`define SIO_BANK_GPIO    8'h07
`define SIO_BANK_GEN     8'h09

// Field positions
`define SIO_GEN_BIT      7

// Reset values and read fill byte
`define SIO_LDN_RST      8'h00
`define SIO_GEN_RST      8'h00
`define SIO_DIR_RST      8'hFF
`define SIO_VAL_RST      8'h00
`define SIO_INV_RST      8'h00
`define SIO_IDX_RST      8'h00
`define SIO_FILL_BYTE    8'hFF

// Controller register map (byte addresses)
`define SIO_HOST_CTRL    8'h00
`define SIO_HOST_STAT    8'h04
`define SIO_HOST_AMASK   8'hFC

// Controller command fields
`define SIO_CTRL_DPORT   8
`define SIO_CTRL_WR      9
`define SIO_CTRL_STRB    1

// AXI responses
`define SIO_RESP_OKAY    2'h0
`define SIO_RESP_SLVERR  2'h2

`endif

// *** rtl/sio_pkg.sv ***
// Types shared by the GPIO configuration port ends
package sio_pkg;

  typedef logic [7:0] sio_byte_t;
  typedef logic [7:0] sio_aaddr_t;
  typedef logic [31:0] sio_word_t;

  typedef enum logic [1:0] {
    SIO_LOCKED = 2'b00,
    SIO_HALF   = 2'b01,
    SIO_OPEN   = 2'b10
  } sio_lock_t;

  typedef enum logic [2:0] {
    SIO_REG_NONE = 3'b000,
    SIO_REG_LDN  = 3'b001,
    SIO_REG_GEN  = 3'b010,
    SIO_REG_DIR  = 3'b011,
    SIO_REG_VAL  = 3'b100,
    SIO_REG_INV  = 3'b101
  } sio_reg_t;

  typedef enum logic [1:0] {
    SIO_H_IDLE  = 2'b00,
    SIO_H_ISSUE = 2'b01,
    SIO_H_WAIT  = 2'b10
  } sio_hstate_t;

endpackage

// *** rtl/sio_port_if.sv ***
// Index/data configuration port between controller and GPIO device
`timescale 1ns/1ps
`default_nettype none

interface sio_port_if;
  logic              io_req;
  logic              io_we;
  sio_pkg::sio_byte_t io_addr;
  sio_pkg::sio_byte_t io_wdata;
  logic              io_ack;
  sio_pkg::sio_byte_t io_rdata;

  modport host (
    output io_req,
    output io_we,
    output io_addr,
    output io_wdata,
    input  io_ack,
    input  io_rdata
  );

  modport dev (
    input  io_req,
    input  io_we,
    input  io_addr,
    input  io_wdata,
    output io_ack,
    output io_rdata
  );
endinterface

`default_nettype wire

// *** rtl/sio_gpio_host.sv ***
// AXI4-Lite controller issuing index/data configuration port cycles
`timescale 1ns/1ps
`default_nettype none
`include "sio_consts.svh"

module sio_gpio_host (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // AXI4-Lite write channels
  input  wire sio_pkg::sio_aaddr_t s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire sio_pkg::sio_word_t s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read channels
  input  wire sio_pkg::sio_aaddr_t s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output sio_pkg::sio_word_t      s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Configuration port
  sio_port_if.host                port
);
  import sio_pkg::*;

  logic        aw_got, next_aw_got;
  sio_aaddr_t  awaddr, next_awaddr;
  logic        w_got, next_w_got;
  sio_word_t   wdata, next_wdata;
  logic [3:0]  wstrb, next_wstrb;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  sio_word_t   rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;
  sio_hstate_t st, next_st;
  logic        cmd_we, next_cmd_we;
  logic        cmd_dport, next_cmd_dport;
  sio_byte_t   cmd_addr, next_cmd_addr;
  sio_byte_t   cmd_data, next_cmd_data;
  sio_byte_t   last_rd, next_last_rd;
  logic        busy;

  assign busy          = (st != SIO_H_IDLE);
  assign s_axi_awready = ~aw_got & ~bvalid;
  assign s_axi_wready  = ~w_got & ~bvalid;
  assign s_axi_arready = ~rvalid;

  always_comb begin
    next_aw_got    = aw_got;
    next_awaddr    = awaddr;
    next_w_got     = w_got;
    next_wdata     = wdata;
    next_wstrb     = wstrb;
    next_bvalid    = bvalid;
    next_bresp     = bresp;
    next_rvalid    = rvalid;
    next_rdata     = rdata;
    next_rresp     = rresp;
    next_st        = st;
    next_cmd_we    = cmd_we;
    next_cmd_dport = cmd_dport;
    next_cmd_addr  = cmd_addr;
    next_cmd_data  = cmd_data;
    next_last_rd   = last_rd;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_wdata = s_axi_wdata;
      next_wstrb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // Write performed once both address and data are held
    if (aw_got && w_got && !bvalid) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = `SIO_RESP_OKAY;
      case (awaddr & `SIO_HOST_AMASK)
        `SIO_HOST_CTRL: begin
          // Commands while busy are dropped
          if (!busy && wstrb[`SIO_CTRL_STRB]) begin
            next_st        = SIO_H_ISSUE;
            next_cmd_we    = wdata[`SIO_CTRL_WR];
            next_cmd_dport = wdata[`SIO_CTRL_DPORT];
            next_cmd_data  = wdata[7:0];
            next_cmd_addr  = wdata[`SIO_CTRL_DPORT] ? `SIO_DATA_PORT :
                                                      `SIO_INDEX_PORT; // RULE3
          end
        end
        `SIO_HOST_STAT: next_bresp = `SIO_RESP_OKAY;
        default:        next_bresp = `SIO_RESP_SLVERR;
      endcase
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = `SIO_RESP_OKAY;
      case (s_axi_araddr & `SIO_HOST_AMASK)
        `SIO_HOST_CTRL: next_rdata = {22'h00_0000, cmd_we, cmd_dport,
                                      cmd_data};
        `SIO_HOST_STAT: next_rdata = {16'h0000, last_rd, 7'h00, busy};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = `SIO_RESP_SLVERR;
        end
      endcase
    end
    // One port cycle at a time; software sequences keys and indices
    case (st)
      SIO_H_IDLE:  next_st = next_st;
      SIO_H_ISSUE: next_st = SIO_H_WAIT; // RULE1 RULE2
      SIO_H_WAIT: begin
        if (port.io_ack) begin
          next_st = SIO_H_IDLE;
          if (!cmd_we) begin
            next_last_rd = port.io_rdata; // RULE4
          end
        end
      end
      default: next_st = SIO_H_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_got    <= 1'b0;
      awaddr    <= 8'h00;
      w_got     <= 1'b0;
      wdata     <= 32'h0000_0000;
      wstrb     <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `SIO_RESP_OKAY;
      rvalid    <= 1'b0;
      rdata     <= 32'h0000_0000;
      rresp     <= `SIO_RESP_OKAY;
      st        <= SIO_H_IDLE;
      cmd_we    <= 1'b0;
      cmd_dport <= 1'b0;
      cmd_addr  <= `SIO_INDEX_PORT;
      cmd_data  <= 8'h00;
      last_rd   <= 8'h00;
    end else begin
      aw_got    <= next_aw_got;
      awaddr    <= next_awaddr;
      w_got     <= next_w_got;
      wdata     <= next_wdata;
      wstrb     <= next_wstrb;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
      st        <= next_st;
      cmd_we    <= next_cmd_we;
      cmd_dport <= next_cmd_dport;
      cmd_addr  <= next_cmd_addr;
      cmd_data  <= next_cmd_data;
      last_rd   <= next_last_rd;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp  = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata  = rdata;
  assign s_axi_rresp  = rresp;
  assign port.io_req   = (st == SIO_H_ISSUE);
  assign port.io_we    = cmd_we;
  assign port.io_addr  = cmd_addr;
  assign port.io_wdata = cmd_data;

endmodule // sio_gpio_host

`default_nettype wire

// *** verif/sio_gpio_monitor.sv ***
// Checker of the configuration port handshake and key sequence
`timescale 1ns/1ps
`default_nettype none
`include "sio_consts.svh"
module sio_gpio_monitor (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // Port signals
  input wire logic               io_req,
  input wire logic               io_we,
  input wire sio_pkg::sio_byte_t io_addr,
  input wire sio_pkg::sio_byte_t io_wdata,
  input wire logic               io_ack,
  input wire sio_pkg::sio_byte_t io_rdata
);
  import sio_pkg::*;
  sio_lock_t st, next_st;
  sio_byte_t idx, next_idx, ldn, next_ldn;
  logic      key, rd, ix;
  assign ix  = io_addr == `SIO_INDEX_PORT;
  assign key = io_req && io_we && ix && io_wdata == `SIO_UNLOCK_KEY;
  assign rd  = io_req && !io_we;

  // Shadow of lock state, index and bank select
  always_comb begin
    next_st  = st;
    next_idx = idx;
    next_ldn = ldn;
    if (io_req) begin
      case (st)
        SIO_LOCKED: next_st = key ? SIO_HALF : SIO_LOCKED;
        SIO_HALF:   next_st = key ? SIO_OPEN : SIO_LOCKED;
        default: begin
          if (io_we && ix && io_wdata == `SIO_LOCK_KEY) next_st = SIO_LOCKED;
          else if (io_we && ix) next_idx = io_wdata;
          else if (io_we && idx == `SIO_LDN_REG) next_ldn = io_wdata;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st  <= SIO_LOCKED;
      idx <= `SIO_IDX_RST;
      ldn <= `SIO_LDN_RST;
    end else begin
      st  <= next_st;
      idx <= next_idx;
      ldn <= next_ldn;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ack_follows_req_a: assert property (io_req |=> io_ack)
    else $error("port cycle not acknowledged next cycle");
  ack_has_cause_a: assert property (io_ack |-> $past(io_req))
    else $error("acknowledge without a port cycle");
  ack_one_cycle_a: assert property (io_ack |=> !io_ack)
    else $error("acknowledge longer than one cycle");
  req_spacing_a: assert property (io_req |=> !io_req)
    else $error("port cycles issued back to back");
  cmd_held_a: assert property (
    io_req |=> $stable({io_we, io_addr, io_wdata}))
    else $error("port command changed before acknowledge");
  rdata_with_ack_a: assert property ($changed(io_rdata) |-> io_ack)
    else $error("read byte changed without acknowledge");
  locked_read_fill_a: assert property (
    rd && st != SIO_OPEN |=> io_rdata == `SIO_FILL_BYTE)
    else $error("locked port read returned register data");
  index_readback_a: assert property (
    rd && st == SIO_OPEN && ix |=> io_rdata == idx)
    else $error("index read back wrong");
  bank_readback_a: assert property (
    rd && st == SIO_OPEN && !ix && idx == `SIO_LDN_REG |=> io_rdata == ldn)
    else $error("bank select read back wrong");
endmodule // sio_gpio_monitor
`default_nettype wire

// *** verif/sio_gpio_config_port_tb_top.sv ***
// Testbench joining controller and GPIO device through the port
`timescale 1ns/1ps
`default_nettype none
`include "sio_consts.svh"
module sio_gpio_config_port_tb_top;
  import sio_pkg::*;
  logic       clk, rst, cfg_open;
  logic       awvalid, wvalid, bready, arvalid, rready;
  logic       awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [3:0] wstrb;
  sio_aaddr_t awaddr, araddr;
  sio_word_t  wdata, rdata, w;
  sio_byte_t  gpio_in, gpio_out, gpio_oe, v;
  int         n_errors, checked;

  sio_port_if u_sio_port_if ();
  sio_gpio_host u_sio_gpio_host (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port(u_sio_port_if));
  sio_gpio_dev u_sio_gpio_dev (.clk(clk), .rst(rst), .port(u_sio_port_if),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .cfg_open(cfg_open));
  sio_gpio_monitor u_sio_gpio_monitor (.clk(clk), .rst(rst),
    .io_req(u_sio_port_if.io_req), .io_we(u_sio_port_if.io_we),
    .io_addr(u_sio_port_if.io_addr), .io_wdata(u_sio_port_if.io_wdata),
    .io_ack(u_sio_port_if.io_ack), .io_rdata(u_sio_port_if.io_rdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input sio_aaddr_t a, input sio_word_t d,
                           output logic [1:0] rs);
    logic ah, dh, got;
    int   i;
    got = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 50 && !got; i++) begin
      @(negedge clk);
      ah  = awvalid && (awready === 1'b1);
      dh  = wvalid && (wready === 1'b1);
      got = bvalid === 1'b1;
      rs  = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (dh) wvalid <= 1'b0;
      if (got) bready <= 1'b0;
    end
    if (!got) begin
      n_errors++;
      report_and_stop();
    end
  endtask

  task automatic axi_read(input sio_aaddr_t a, output sio_word_t d,
                          output logic [1:0] rs);
    logic ah, got;
    int   i;
    got = 1'b0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 50 && !got; i++) begin
      @(negedge clk);
      ah  = arvalid && (arready === 1'b1);
      got = rvalid === 1'b1;
      d   = rdata;
      rs  = rresp;
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (got) rready <= 1'b0;
    end
    if (!got) begin
      n_errors++;
      report_and_stop();
    end
  endtask

  // One port cycle through the controller, waiting for busy to drop
  task automatic port_op(input logic we, input logic dp, input sio_byte_t b,
                         output sio_byte_t rd);
    sio_word_t  s;
    logic [1:0] rs;
    int         i;
    axi_write(`SIO_HOST_CTRL, {22'h0, we, dp, b}, rs);
    check(rs, `SIO_RESP_OKAY);
    s = 32'h0000_0001;
    for (i = 0; i < 50 && s[0] !== 1'b0; i++) axi_read(`SIO_HOST_STAT, s, rs);
    if (s[0] !== 1'b0) begin
      n_errors++;
      report_and_stop();
    end
    check(rs, `SIO_RESP_OKAY);
    rd = s[15:8];
  endtask

  task automatic pw(input logic dp, input sio_byte_t b);
    sio_byte_t x;
    port_op(1'b1, dp, b, x);
  endtask

  task automatic reg_wr(input sio_byte_t a, input sio_byte_t d);
    pw(1'b0, a);
    pw(1'b1, d);
  endtask

  task automatic reg_rd(input sio_byte_t a, output sio_byte_t d);
    pw(1'b0, a);
    port_op(1'b0, 1'b1, 8'h00, d);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    gpio_in = 8'h00;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check(cfg_open, 1'b0);
    check(gpio_oe, 8'h00);
    axi_read(8'h08, w, r);
    check(r, `SIO_RESP_SLVERR);
    check(w, 32'h0000_0000);
    axi_write(8'h08, 32'h0000_0000, r);
    check(r, `SIO_RESP_SLVERR);
    axi_write(`SIO_HOST_STAT, 32'h0000_0000, r);
    check(r, `SIO_RESP_OKAY);
    port_op(1'b0, 1'b1, 8'h00, v);
    check(v, `SIO_FILL_BYTE);
    // Unlock broken by a read, then a full double write
    pw(1'b0, `SIO_UNLOCK_KEY);
    port_op(1'b0, 1'b1, 8'h00, v);
    check(v, `SIO_FILL_BYTE);
    pw(1'b0, `SIO_UNLOCK_KEY);
    check(cfg_open, 1'b0);
    pw(1'b0, `SIO_UNLOCK_KEY);
    check(cfg_open, 1'b1);
    reg_wr(`SIO_LDN_REG, `SIO_BANK_GEN);
    reg_rd(`SIO_GEN_REG, v);
    check(v, 8'h00);
    reg_wr(`SIO_GEN_REG, v | 8'h80);
    reg_rd(`SIO_GEN_REG, v);
    check(v, 8'h80);
    port_op(1'b0, 1'b0, 8'h00, v);
    check(v, `SIO_GEN_REG);
    reg_rd(`SIO_LDN_REG, v);
    check(v, `SIO_BANK_GEN);
    // GPIO registers are not reachable from the enable bank
    reg_rd(`SIO_DIR_REG, v);
    check(v, `SIO_FILL_BYTE);
    reg_wr(`SIO_LDN_REG, `SIO_BANK_GPIO);
    check(gpio_oe, 8'h00);
    reg_rd(`SIO_DIR_REG, v);
    check(v, `SIO_DIR_RST);
    reg_wr(`SIO_DIR_REG, 8'h0F);
    check(gpio_oe, 8'hF0);
    gpio_in <= 8'h3C;
    reg_wr(`SIO_INV_REG, 8'h00);
    reg_wr(`SIO_VAL_REG, 8'hA5);
    check(gpio_out, 8'hA0);
    reg_rd(`SIO_VAL_REG, v);
    check(v, 8'hAC);
    reg_wr(`SIO_INV_REG, 8'hFF);
    check(gpio_out, 8'h5F);
    reg_rd(`SIO_VAL_REG, v);
    check(v, 8'hA3);
    reg_wr(`SIO_LDN_REG, `SIO_BANK_GEN);
    reg_wr(`SIO_GEN_REG, 8'h00);
    check(gpio_oe, 8'h00);
    // Command without lane 1 strobe is ignored, lock key not sent
    wstrb <= 4'h1;
    axi_write(`SIO_HOST_CTRL, 32'h0000_02AA, r);
    check(r, `SIO_RESP_OKAY);
    wstrb <= 4'hF;
    axi_read(`SIO_HOST_STAT, w, r);
    check(w[0], 1'b0);
    check(cfg_open, 1'b1);
    axi_read(`SIO_HOST_CTRL, w, r);
    check(w, 32'h0000_0300);
    pw(1'b0, `SIO_LOCK_KEY);
    check(cfg_open, 1'b0);
    port_op(1'b0, 1'b1, 8'h00, v);
    check(v, `SIO_FILL_BYTE);
    report_and_stop();
  end
endmodule // sio_gpio_config_port_tb_top
`default_nettype wire
